// ===== sat_defs.svh
`ifndef SAT_DEFS_SVH
`define SAT_DEFS_SVH

// ****************************************************************
// Bus decode
// ****************************************************************
`define SAT_ADDR_W          8
`define SAT_DATA_W          8
`define SAT_ADDR_LOW        8'h75
`define SAT_ADDR_HIGH       8'h76

// ****************************************************************
// High byte field positions
// ****************************************************************
`define SAT_HI_CODE_LSB     0
`define SAT_HI_CODE_MSB     1
`define SAT_HI_TRIM_A       3
`define SAT_HI_TRIM_B       4
`define SAT_HI_DEC_A        5
`define SAT_HI_DEC_B        6
`define SAT_HI_POLARITY     7

// ****************************************************************
// Attenuation code
// ****************************************************************
`define SAT_CODE_W          10
`define SAT_CODE_LEVELS     1024

// ****************************************************************
// Output enable vector positions
// ****************************************************************
`define SAT_TRIM_MAIN       0
`define SAT_TRIM_FM         1
`define SAT_TRIM_LO2        2
`define SAT_RELAY_X1        0
`define SAT_RELAY_X0P1      1
`define SAT_RELAY_X0P01     2

// ****************************************************************
// Reset values
// ****************************************************************
`define SAT_RST_BYTE        8'h00
`define SAT_RST_EN3         3'h0

`endif

// ===== sat_pkg.sv
package sat_pkg;

    // ****************************************************************
    // State of the bus capture logic
    // ****************************************************************
    typedef struct packed {
        logic       strobe_d;
        logic       hit_low;
        logic       hit_high;
        logic [7:0] data_hold;
        logic [7:0] low_byte;
        logic [7:0] high_byte;
    } sat_cap_st_t;

    // ****************************************************************
    // State of the field decoder
    // ****************************************************************
    typedef struct packed {
        logic [2:0] trim_en;
        logic [2:0] relay_en;
    } sat_dec_st_t;

endpackage

// ===== sat_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries the high control byte to the decoder and its enables back
interface sat_ctl_if;
    logic [7:0] high_byte;
    logic [2:0] trim_en;
    logic [2:0] relay_en;

    modport ctl (output high_byte, input trim_en, input relay_en);
    modport dec (input high_byte, output trim_en, output relay_en);
endinterface

`default_nettype wire

// ===== sat_field_decode.sv
`include "sat_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sat_field_decode (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   arst_n,
    // Control byte in, enables out
    sat_ctl_if.dec      ctl
);

    sat_pkg::sat_dec_st_t st;
    sat_pkg::sat_dec_st_t next_st;

    // ****************************************************************
    // Decode of trim and decade fields
    // ****************************************************************

    // Registered so relay drivers never see decode glitches
    always_comb begin
        next_st = st;
        case ({ctl.high_byte[`SAT_HI_TRIM_A], ctl.high_byte[`SAT_HI_TRIM_B]})
            2'h0:    next_st.trim_en = 3'h1; // Main coil
            2'h1:    next_st.trim_en = 3'h2; // FM coil
            2'h2:    next_st.trim_en = 3'h4; // Second oscillator
            default: next_st.trim_en = 3'h0; // Unlisted code, no trim
        endcase
        case ({ctl.high_byte[`SAT_HI_DEC_A], ctl.high_byte[`SAT_HI_DEC_B]})
            2'h0:    next_st.relay_en = 3'h1; // x1
            2'h2:    next_st.relay_en = 3'h2; // x0.1
            2'h1:    next_st.relay_en = 3'h4; // x0.01
            default: next_st.relay_en = 3'h0; // Unlisted code, no relay
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st.trim_en  <= `SAT_RST_EN3;
            st.relay_en <= `SAT_RST_EN3;
        end else begin
            st <= next_st;
        end
    end

    assign ctl.trim_en  = st.trim_en;
    assign ctl.relay_en = st.relay_en;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_trim_exclusive: assert property (@(posedge clk) disable iff (!arst_n)
        $onehot0(st.trim_en))
        else $error("more than one trim enabled");

    a_trim_decode: assert property (@(posedge clk) disable iff (!arst_n)
        ({ctl.high_byte[`SAT_HI_TRIM_A], ctl.high_byte[`SAT_HI_TRIM_B]} == 2'h1)
        |=> (st.trim_en == 3'h2))
        else $error("trim code 01 did not select FM coil");

    a_relay_decode: assert property (@(posedge clk) disable iff (!arst_n)
        ({ctl.high_byte[`SAT_HI_DEC_A], ctl.high_byte[`SAT_HI_DEC_B]} != 2'h3)
        |=> $onehot(st.relay_en) && (st.relay_en[`SAT_RELAY_X0P1]
            == ($past(ctl.high_byte[`SAT_HI_DEC_A]) && !$past(ctl.high_byte[`SAT_HI_DEC_B]))))
        else $error("relay decode wrong for listed code");

    a_unused_codes: assert property (@(posedge clk) disable iff (!arst_n)
        (ctl.high_byte[`SAT_HI_DEC_A] && ctl.high_byte[`SAT_HI_DEC_B])
        |=> (st.relay_en == 3'h0))
        else $error("relay driven for code 11");

endmodule

`default_nettype wire

// ===== sat_span_ctrl.sv
// Overview of operation
// - While the data strobe is high, address 75 pulls the low select low and 76 the high one.
// - The addressed byte is stored when the strobe falls and held until that address is rewritten.
// - The low byte is the eight least significant bits of the attenuation code.
// - The high byte carries the two top code bits plus polarity, trim and decade fields.
// - Polarity bit low selects the inverting path, high the non-inverting one.
// - The ten code bits together choose one of 1024 evenly spaced attenuation levels.
// - Trim bits a,b decode 00 main coil, 01 FM coil, 10 second oscillator, one at most.
// - Decade bits a,b decode 00 x1, 10 x0.1, 01 x0.01, exactly one relay each.
`include "sat_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sat_span_ctrl #(
    parameter int CODE_W = `SAT_CODE_W
) (
    // Clock and reset
    input  wire logic              SYS_CLK,
    input  wire logic              ARST_N,
    // Host bus
    input  wire logic [7:0]        ADDR,
    input  wire logic [7:0]        DATA,
    input  wire logic              DATA_VALID,
    // Latch selects, active low
    output logic                   SEL_LOW_N,
    output logic                   SEL_HIGH_N,
    // Attenuator code and path
    output logic [CODE_W-1:0]      ATTEN_CODE,
    output logic                   SWEEP_NONINVERT,
    // Calibration trims
    output logic                   TRIM_MAIN_EN,
    output logic                   TRIM_FM_EN,
    output logic                   TRIM_LO2_EN,
    // Decade relays
    output logic                   RELAY_X1,
    output logic                   RELAY_X0P1,
    output logic                   RELAY_X0P01
);

    sat_pkg::sat_cap_st_t st;
    sat_pkg::sat_cap_st_t next_st;
    logic                 hit_low;
    logic                 hit_high;
    logic                 strobe_fall;

    sat_ctl_if ctl ();

    // ****************************************************************
    // Address decode
    // ****************************************************************

    // Selects only while the strobe is high
    // Pure decode with no flop, so a select may glitch while the address settles
    assign hit_low    = DATA_VALID && (ADDR == `SAT_ADDR_LOW);
    assign hit_high   = DATA_VALID && (ADDR == `SAT_ADDR_HIGH);
    assign SEL_LOW_N  = !hit_low;
    assign SEL_HIGH_N = !hit_high;

    // Trailing edge of the strobe, seen one clock late
    // Costs a cycle of latency but keeps every commit on the system clock
    assign strobe_fall = st.strobe_d && !DATA_VALID;

    // ****************************************************************
    // Capture on the trailing edge
    // ****************************************************************

    // Address and byte are sampled while the strobe is high, because at
    // the falling edge the host may already be moving the bus
    always_comb begin
        next_st = st;
        next_st.strobe_d = DATA_VALID;
        if (DATA_VALID) begin
            next_st.hit_low   = hit_low;
            next_st.hit_high  = hit_high;
            next_st.data_hold = DATA;
        end
        if (strobe_fall) begin
            if (st.hit_low) begin
                next_st.low_byte = st.data_hold;
            end
            if (st.hit_high) begin
                next_st.high_byte = st.data_hold;
            end
            next_st.hit_low  = 1'b0;
            next_st.hit_high = 1'b0;
        end
    end

    // State register, no reset value is defined so bytes clear to zero
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st.strobe_d  <= 1'b0;
            st.hit_low   <= 1'b0;
            st.hit_high  <= 1'b0;
            st.data_hold <= `SAT_RST_BYTE;
            st.low_byte  <= `SAT_RST_BYTE;
            st.high_byte <= `SAT_RST_BYTE;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Field outputs
    // ****************************************************************

    // High bits on top of the low byte; bit one means level high
    assign ATTEN_CODE = {st.high_byte[`SAT_HI_CODE_MSB:`SAT_HI_CODE_LSB], st.low_byte};
    // Low selects gain -1, high selects gain +1
    assign SWEEP_NONINVERT = st.high_byte[`SAT_HI_POLARITY];

    // Code updates per byte as each lands; the host pairs the two writes
    // Trim and relay decode lives in the leaf
    assign ctl.high_byte = st.high_byte;

    sat_field_decode u_decode (
        .clk    (SYS_CLK),
        .arst_n (ARST_N),
        .ctl    (ctl)
    );

    // Positive logic drive to the switches and relays
    assign TRIM_MAIN_EN = ctl.trim_en[`SAT_TRIM_MAIN];
    assign TRIM_FM_EN   = ctl.trim_en[`SAT_TRIM_FM];
    assign TRIM_LO2_EN  = ctl.trim_en[`SAT_TRIM_LO2];
    assign RELAY_X1     = ctl.relay_en[`SAT_RELAY_X1];
    assign RELAY_X0P1   = ctl.relay_en[`SAT_RELAY_X0P1];
    assign RELAY_X0P01  = ctl.relay_en[`SAT_RELAY_X0P01];

    // ****************************************************************
    // Checks
    // ****************************************************************

    // A write: strobe high on an address, then strobe low
    sequence s_write_low;
        (DATA_VALID && ADDR == `SAT_ADDR_LOW) ##1 !DATA_VALID;
    endsequence

    sequence s_write_high;
        (DATA_VALID && ADDR == `SAT_ADDR_HIGH) ##1 !DATA_VALID;
    endsequence

    a_select_low: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        !SEL_LOW_N |-> DATA_VALID && SEL_HIGH_N)
        else $error("low select without strobe or with high select");

    a_capture_low: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        s_write_low |=> ATTEN_CODE[7:0] == $past(DATA, 2))
        else $error("low byte not captured at strobe fall");

    a_capture_high: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        s_write_high |=> st.high_byte == $past(DATA, 2))
        else $error("high byte not captured at strobe fall");

    a_hold_bytes: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        !strobe_fall |=> $stable(st.low_byte) && $stable(st.high_byte))
        else $error("latched byte changed without a write");

    a_code_join: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        s_write_high |=> ATTEN_CODE[CODE_W-1:8] == $past(DATA[1:0], 2))
        else $error("top code bits not taken from high byte");

    a_polarity_path: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        s_write_high |=> SWEEP_NONINVERT == $past(DATA[7], 2) ##1 $stable(SWEEP_NONINVERT))
        else $error("polarity does not follow high byte");

    a_relay_follow: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (s_write_high ##0 $past(DATA[6:5]) == 2'h0) |=> ##1 RELAY_X1 && !RELAY_X0P1)
        else $error("x1 relay not driven for code 00");

    // Selects never overlap and both stay off without a strobe
    a_select_high: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        !SEL_HIGH_N |-> DATA_VALID && SEL_LOW_N)
        else $error("high select without strobe or with low select");

    a_select_idle: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        !DATA_VALID |-> SEL_LOW_N && SEL_HIGH_N)
        else $error("select active while strobe is low");

    a_select_decode: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (DATA_VALID && ADDR == `SAT_ADDR_HIGH) |-> !SEL_HIGH_N)
        else $error("high select missing for its address");

    // A strobe on any other address must leave both bytes alone
    sequence s_write_other;
        (DATA_VALID && ADDR != `SAT_ADDR_LOW && ADDR != `SAT_ADDR_HIGH) ##1 !DATA_VALID;
    endsequence

    a_foreign_ignored: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        s_write_other |=> $stable(st.low_byte) && $stable(st.high_byte))
        else $error("byte changed by a write to another address");

    // Each write touches only its own latch
    a_low_keeps_high: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        s_write_low |=> $stable(st.high_byte))
        else $error("high byte changed by a low write");

    a_high_keeps_low: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        s_write_high |=> $stable(st.low_byte))
        else $error("low byte changed by a high write");

    // Polarity bit low must pick the inverting path
    a_polarity_invert: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (s_write_high ##0 !$past(DATA[`SAT_HI_POLARITY])) |=> !SWEEP_NONINVERT)
        else $error("inverting path not selected for polarity low");

    // Trims and relays follow one edge after the byte lands
    a_trim_lo2: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (s_write_high ##0 ($past(DATA[`SAT_HI_TRIM_A]) && !$past(DATA[`SAT_HI_TRIM_B])))
        |=> ##1 TRIM_LO2_EN && !TRIM_MAIN_EN && !TRIM_FM_EN)
        else $error("second oscillator trim not alone for code 10");

    a_relay_x0p01: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (s_write_high ##0 (!$past(DATA[`SAT_HI_DEC_A]) && $past(DATA[`SAT_HI_DEC_B])))
        |=> ##1 RELAY_X0P01 && !RELAY_X1 && !RELAY_X0P1)
        else $error("x0.01 relay not alone for code 01");

    // Unlisted trim code must leave every trim off
    a_trim_none: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (s_write_high ##0 ($past(DATA[`SAT_HI_TRIM_A]) && $past(DATA[`SAT_HI_TRIM_B])))
        |=> ##1 !TRIM_MAIN_EN && !TRIM_FM_EN && !TRIM_LO2_EN)
        else $error("trim enabled for code 11");

endmodule

`default_nettype wire

// ===== sat_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ********
// Host bus model
// ********
// Released lines show the inverse of the last value, never a stale byte
module sat_host_model (
    // Clock
    input  wire logic  clk,
    // Bus
    output logic [7:0] addr,
    output logic [7:0] data,
    output logic       valid
);
    // Idle bus at time zero
    initial begin
        addr  = 8'h00;
        data  = 8'h00;
        valid = 1'b0;
    end

    // Raise strobe with address and byte; held until stop
    task automatic start(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        data  <= d;
        valid <= 1'b1;
    endtask

    // Drop strobe and scramble the released lines
    task automatic stop();
        @(posedge clk);
        valid <= 1'b0;
        addr  <= ~addr;
        data  <= ~data;
    endtask

    // One byte per strobe pulse, caller picks any address and byte value
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        start(a, d);
        stop();
    endtask
endmodule

`default_nettype wire

// ===== tb_span_attenuator_control.sv
`timescale 1ns/1ps
`default_nettype none

// ********
// Bench
// ********
module tb_span_attenuator_control;
    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic [9:0] code;
        logic       pol;
        logic [2:0] trim;
        logic [2:0] relay;
    } sat_row_t;

    logic       sys_clk = 1'b0;
    logic       arst_n  = 1'b0;
    logic [7:0] addr;
    logic [7:0] data;
    logic       valid;
    logic       sel_low_n;
    logic       sel_high_n;
    logic [9:0] code;
    logic       pol;
    wire  [2:0] trim;
    wire  [2:0] relay;
    int         n_fail      = 0;
    int         check_count = 0;
    // Trim {lo2,fm,main}, relay {x0p01,x0p1,x1}
    sat_row_t   rows [6] = '{
        '{8'h67, 8'h00, 10'h067, 1'b0, 3'b001, 3'b001},
        '{8'hFF, 8'h83, 10'h3FF, 1'b1, 3'b001, 3'b001},
        '{8'h5A, 8'h12, 10'h25A, 1'b0, 3'b010, 3'b001},
        '{8'hA5, 8'h29, 10'h1A5, 1'b0, 3'b100, 3'b010},
        '{8'hFF, 8'hC0, 10'h0FF, 1'b1, 3'b001, 3'b100},
        '{8'h80, 8'h7A, 10'h280, 1'b0, 3'b000, 3'b000}};

    always #5 sys_clk = ~sys_clk;

    sat_host_model u_sat_host_model (.clk(sys_clk), .addr(addr), .data(data), .valid(valid));

    sat_span_ctrl u_sat_span_ctrl (
        .SYS_CLK(sys_clk), .ARST_N(arst_n), .ADDR(addr), .DATA(data),
        .DATA_VALID(valid), .SEL_LOW_N(sel_low_n), .SEL_HIGH_N(sel_high_n),
        .ATTEN_CODE(code), .SWEEP_NONINVERT(pol), .TRIM_MAIN_EN(trim[0]),
        .TRIM_FM_EN(trim[1]), .TRIM_LO2_EN(trim[2]), .RELAY_X1(relay[0]),
        .RELAY_X0P1(relay[1]), .RELAY_X0P01(relay[2]));

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // All decoded outputs against one row
    task automatic chk_all(input sat_row_t r);
        chk({6'h00, code}, {6'h00, r.code});
        chk({15'h0000, pol}, {15'h0000, r.pol});
        chk({13'h0000, trim}, {13'h0000, r.trim});
        chk({13'h0000, relay}, {13'h0000, r.relay});
    endtask

    // Selects during and after a strobe
    task automatic sel_probe(input logic [7:0] a, input logic [1:0] exp);
        u_sat_host_model.start(a, 8'h80);
        #1;
        chk({14'h0000, sel_high_n, sel_low_n}, {14'h0000, exp});
        u_sat_host_model.stop();
        #1;
        chk({14'h0000, sel_high_n, sel_low_n}, 16'h0003);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        end_sim();
    end

    // Main sequence
    initial begin
        @(posedge sys_clk);
        #1;
        chk_all('{8'h00, 8'h00, 10'h000, 1'b0, 3'b000, 3'b000});
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk_all('{8'h00, 8'h00, 10'h000, 1'b0, 3'b001, 3'b001});
        foreach (rows[i]) begin
            u_sat_host_model.write(8'h75, rows[i].lo);
            u_sat_host_model.write(8'h76, rows[i].hi);
            repeat (2) @(posedge sys_clk);
            #1;
            chk_all(rows[i]);
        end
        // Foreign addresses ignored, high byte held over a low rewrite
        u_sat_host_model.write(8'h74, 8'hFF);
        u_sat_host_model.write(8'h77, 8'hFF);
        u_sat_host_model.write(8'h75, 8'h3C);
        repeat (2) @(posedge sys_clk);
        #1;
        chk_all('{8'h3C, 8'h7A, 10'h23C, 1'b0, 3'b000, 3'b000});
        sel_probe(8'h75, 2'b10);
        sel_probe(8'h76, 2'b01);
        sel_probe(8'h74, 2'b11);
        // Second reset in mid-run clears everything at once
        @(posedge sys_clk);
        arst_n <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk_all('{8'h00, 8'h00, 10'h000, 1'b0, 3'b000, 3'b000});
        @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk_all('{8'h00, 8'h00, 10'h000, 1'b0, 3'b001, 3'b001});
        end_sim();
    end
endmodule

`default_nettype wire
